//--- design/gas_cmd_pkg.sv
package gas_cmd_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int STREAM_PERIOD_MS = 500;
  localparam int HOLDOFF_MS = 100;
  localparam int STREAM_CYC = STREAM_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int HOLDOFF_CYC = HOLDOFF_MS * 1000 * CLK_MHZ;
  localparam int DIGITS = 5;
  // ----------------------------------------
  // Characters
  // ----------------------------------------
  localparam logic [7:0] CH_RAW = 8'h7A;
  localparam logic [7:0] CH_FILT = 8'h5A;
  localparam logic [7:0] CH_SCALE = 8'h2E;
  localparam logic [7:0] CH_TEMP = 8'h54;
  localparam logic [7:0] CH_HUM = 8'h48;
  localparam logic [7:0] CH_MASK = 8'h4D;
  localparam logic [7:0] CH_PARAM = 8'h50;
  localparam logic [7:0] CH_MODE = 8'h4B;
  localparam logic [7:0] CH_ALL = 8'h51;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_NONE = 8'h00;
  // ----------------------------------------
  // Values and reset states
  // ----------------------------------------
  localparam logic [15:0] SCALE_LOW = 16'h000A;
  localparam logic [15:0] SCALE_HIGH = 16'h0064;
  localparam logic [15:0] MASK_ALL = 16'h1044;
  localparam logic [15:0] FS_HIGH_SEL = 16'h0000;
  localparam logic [15:0] FS_LOW_SEL = 16'h0001;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_STREAM = 2'h1;
  localparam logic [1:0] MODE_POLL = 2'h2;
  localparam logic [1:0] MODE_RESET = MODE_STREAM;
  localparam logic [7:0] FS_RESET = 8'h00;
endpackage

//--- design/byte_stream_if.sv
`timescale 1ns/1ps
// Byte stream from the reply writer to the output buffer
interface byte_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

//--- design/tx_skid_buf.sv
`timescale 1ns/1ps
module tx_skid_buf
  import gas_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  byte_stream_if.snk in_s,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [7:0] o_data_q, o_data_d, s_data_q, s_data_d;
  logic o_vld_q, o_vld_d, s_vld_q, s_vld_d;
  logic acc, drain;

  // ----------------------------------------
  // Two entries: output stage and spare
  // ----------------------------------------
  // Ready depends only on the spare, so no path from out_ready to the writer
  assign in_s.ready = !s_vld_q;
  assign out_data = o_data_q;
  assign out_valid = o_vld_q;

  always_comb begin
    acc = in_s.valid && !s_vld_q;
    drain = !o_vld_q || out_ready;
    o_data_d = o_data_q;
    o_vld_d = o_vld_q;
    s_data_d = s_data_q;
    s_vld_d = s_vld_q;
    if (drain) begin
      if (s_vld_q) begin
        o_data_d = s_data_q;
        o_vld_d = 1'b1;
        s_vld_d = 1'b0;
      end else begin
        o_data_d = acc ? in_s.data : o_data_q;
        o_vld_d = acc;
      end
    end else if (acc) begin
      s_data_d = in_s.data;
      s_vld_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      o_data_q <= 8'h00;
      o_vld_q <= 1'b0;
      s_data_q <= 8'h00;
      s_vld_q <= 1'b0;
    end else begin
      o_data_q <= o_data_d;
      o_vld_q <= o_vld_d;
      s_data_q <= s_data_d;
      s_vld_q <= s_vld_d;
    end
  end

  // Stalled word stays put until taken
  a_buf_hold_word: assert property (@(posedge sys_clk) disable iff (sys_rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer dropped a stalled word");
endmodule

//--- design/gas_cmd_port.sv
`timescale 1ns/1ps
// Contract
// - Lower-case z replies with latest unfiltered CO2 in five digits.
// - Upper-case Z replies with latest filtered CO2 in scaled units.
// - Period command replies with the scaling multiplier, five digits.
// - Multiplier is 10 for up to sixty percent range, 100 otherwise.
// - Temperature code is ten times Celsius plus one thousand.
// - Humidity code is ten times percent relative humidity.
// - Without the humidity and temperature option those replies are zero.
// - Default output is filtered CO2; mask 4164 adds humidity and temperature.
// - Combined line: humidity, temperature, filtered CO2, spaces between, CR LF.
// - Analogue output on when full scale nonzero, off when both zero.
// - Mode command: 0 sleep, 1 streaming, 2 polling; streaming is default.
// - Sleep answers at once and rejects measurement commands.
// - Sleep mode is not kept over a power cycle.
// - Power-up restores the last streaming or polling mode.
// - Streaming sends twice a second; command hold-off at most 100 ms.
// - Polling measures but only sends readings when asked.
module gas_cmd_port
  import gas_cmd_pkg::*;
#(
  parameter int STREAM_CYCLES = STREAM_CYC,
  parameter int HOLDOFF_CYCLES = HOLDOFF_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [15:0] co2_filt,
  input wire logic [15:0] co2_raw,
  input wire logic [15:0] temp_code,
  input wire logic [15:0] hum_code,
  input wire logic th_fitted,
  input wire logic range_high,
  input wire logic meas_busy,
  input wire logic [1:0] saved_mode,
  output logic [1:0] ctrl_mode,
  output logic [1:0] keep_mode,
  output logic meas_enable,
  output logic analog_en,
  output logic [15:0] analog_scale
);
  typedef enum logic [2:0] {S_IDLE, S_SEP, S_LET, S_SPC, S_DIG, S_CR, S_LF} ser_t;

  function automatic logic [15:0] pow10(input logic [2:0] i);
    unique case (i)
      3'h0: pow10 = 16'h2710;
      3'h1: pow10 = 16'h03E8;
      3'h2: pow10 = 16'h0064;
      3'h3: pow10 = 16'h000A;
      default: pow10 = 16'h0001;
    endcase
  endfunction

  function automatic logic [15:0] opt_val(input logic fitted, input logic [15:0] v);
    opt_val = fitted ? v : 16'h0000;
  endfunction

  byte_stream_if bs();

  // ----------------------------------------
  // Command receiver
  // ----------------------------------------
  logic at_start_q, at_start_d, cr_q, cr_d, dig_q, dig_d, argn_q, argn_d;
  logic [7:0] letter_q, letter_d, pcmd_q, pcmd_d;
  logic [15:0] arg_q [2];
  logic [15:0] arg_d [2];
  logic [15:0] parg_q [2];
  logic [15:0] parg_d [2];
  logic [1:0] pargn_q, pargn_d;
  logic pend_q, pend_d, take;

  // Bytes only gather until LF; nothing acts before the CR LF pair
  always_comb begin
    at_start_d = at_start_q;
    cr_d = cr_q;
    dig_d = dig_q;
    argn_d = argn_q;
    letter_d = letter_q;
    arg_d = arg_q;
    pcmd_d = pcmd_q;
    parg_d = parg_q;
    pargn_d = pargn_q;
    pend_d = pend_q && !take;
    if (rx_valid) begin
      cr_d = 1'b0;
      if (rx_byte == CH_LF) begin
        if (cr_q && !at_start_q) begin
          pend_d = 1'b1;
          pcmd_d = letter_q;
          parg_d = arg_q;
          pargn_d = 2'({1'b0, argn_q} + {1'b0, dig_q});
        end
        at_start_d = 1'b1;
        argn_d = 1'b0;
        dig_d = 1'b0;
        arg_d[0] = 16'h0000;
        arg_d[1] = 16'h0000;
      end else if (rx_byte == CH_CR) begin
        cr_d = 1'b1;
      end else if (at_start_q) begin
        letter_d = rx_byte;
        at_start_d = 1'b0;
      end else if (rx_byte == CH_SP) begin
        if (dig_q && !argn_q) begin
          argn_d = 1'b1;
          dig_d = 1'b0;
        end
      end else if (rx_byte >= CH_0 && rx_byte <= CH_9) begin
        // Extra digits wrap silently; host keeps within 16 bits
        arg_d[argn_q] = 16'(arg_q[argn_q] * 16'h000A + {8'h00, rx_byte - CH_0});
        dig_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      at_start_q <= 1'b1;
      cr_q <= 1'b0;
      dig_q <= 1'b0;
      argn_q <= 1'b0;
      letter_q <= 8'h00;
      arg_q <= '{16'h0000, 16'h0000};
      pcmd_q <= 8'h00;
      parg_q <= '{16'h0000, 16'h0000};
      pargn_q <= 2'h0;
      pend_q <= 1'b0;
    end else begin
      at_start_q <= at_start_d;
      cr_q <= cr_d;
      dig_q <= dig_d;
      argn_q <= argn_d;
      letter_q <= letter_d;
      arg_q <= arg_d;
      pcmd_q <= pcmd_d;
      parg_q <= parg_d;
      pargn_q <= pargn_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------
  // Control state, pacing and reply writer
  // ----------------------------------------
  ser_t st_q, st_d;
  logic [1:0] mode_q, mode_d, keep_q, keep_d;
  logic boot_q, comb_q, comb_d, men_q, men_d, aen_q, aen_d, spend_q, spend_d;
  logic [7:0] fs_hi_q, fs_hi_d, fs_lo_q, fs_lo_d;
  logic [25:0] tick_q, tick_d;
  logic [23:0] hold_q, hold_d;
  logic [7:0] let_q [3];
  logic [7:0] let_d [3];
  logic [15:0] val_q [3];
  logic [15:0] val_d [3];
  logic [1:0] nf_q, nf_d, fi_q, fi_d;
  logic [2:0] pi_q, pi_d;
  logic [3:0] dg_q, dg_d;
  logic [15:0] rem_q, rem_d, scale_val;
  logic sleeping, is_meas, go_stream;

  assign sleeping = (mode_q == MODE_SLEEP);
  assign scale_val = range_high ? SCALE_HIGH : SCALE_LOW;
  assign is_meas = pcmd_q inside {CH_RAW, CH_FILT, CH_TEMP, CH_HUM, CH_ALL};
  // Sleep skips the hold-off; elsewhere wait for the measurement or the cap
  assign take = pend_q && (st_q == S_IDLE) &&
                (sleeping || !meas_busy || hold_q >= 24'(HOLDOFF_CYCLES - 1));
  assign go_stream = spend_q && (st_q == S_IDLE) && !take && (mode_q == MODE_STREAM);

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    keep_d = keep_q;
    comb_d = comb_q;
    fs_hi_d = fs_hi_q;
    fs_lo_d = fs_lo_q;
    aen_d = aen_q;
    let_d = let_q;
    val_d = val_q;
    nf_d = nf_q;
    fi_d = fi_q;
    pi_d = pi_q;
    dg_d = dg_q;
    rem_d = rem_q;
    bs.data = 8'h00;
    bs.valid = 1'b0;
    // Stream pacing counter free-runs in every mode, sleep included
    tick_d = (tick_q >= 26'(STREAM_CYCLES - 1)) ? 26'h0 : 26'(tick_q + 26'h1);
    // A request left over from streaming dies, so sleep and polling stay quiet
    spend_d = ((spend_q && !go_stream) || tick_q == 26'h0) &&
              (mode_q == MODE_STREAM);
    // Hold counter saturates at the cap, so a long reply cannot push it past
    hold_d = (pend_q && !take && meas_busy) ?
             ((hold_q < 24'(HOLDOFF_CYCLES - 1)) ? 24'(hold_q + 24'h1) : hold_q) : 24'h0;
    if (boot_q) begin
      // Power-up mode from the saved copy; sleep is never saved
      mode_d = (saved_mode == MODE_POLL) ? MODE_POLL : MODE_STREAM;
      keep_d = mode_d;
    end
    unique case (st_q)
      S_IDLE: begin
        if (take && !(sleeping && is_meas)) begin
          st_d = S_LET;
          fi_d = 2'h0;
          nf_d = 2'h0;
          let_d[0] = pcmd_q;
          val_d[0] = parg_q[0];
          unique case (pcmd_q)
            CH_RAW: val_d[0] = co2_raw;
            CH_FILT: val_d[0] = co2_filt;
            CH_SCALE: val_d[0] = scale_val;
            CH_TEMP: val_d[0] = opt_val(th_fitted, temp_code);
            CH_HUM: val_d[0] = opt_val(th_fitted, hum_code);
            CH_ALL: begin
              let_d = '{CH_HUM, CH_TEMP, CH_FILT};
              val_d = '{opt_val(th_fitted, hum_code), opt_val(th_fitted, temp_code), co2_filt};
              nf_d = 2'h2;
            end
            CH_MASK: if (pargn_q != 2'h0) begin
              comb_d = (parg_q[0] == MASK_ALL);
            end
            CH_MODE: begin
              if (pargn_q != 2'h0 && parg_q[0] <= 16'h0002) begin
                mode_d = parg_q[0][1:0];
                if (parg_q[0][1:0] != MODE_SLEEP) begin
                  keep_d = parg_q[0][1:0];
                end
              end
              val_d[0] = {14'h0, mode_d};
            end
            CH_PARAM: begin
              let_d[1] = CH_NONE;
              val_d[1] = parg_q[1];
              nf_d = 2'h1;
              if (parg_q[0] == FS_HIGH_SEL) begin
                fs_hi_d = parg_q[1][7:0];
              end else if (parg_q[0] == FS_LOW_SEL) begin
                fs_lo_d = parg_q[1][7:0];
              end
              aen_d = ({fs_hi_d, fs_lo_d} != 16'h0000);
            end
            default: st_d = S_IDLE; // Unknown letters get no answer
          endcase
        end else if (go_stream) begin
          st_d = S_LET;
          fi_d = 2'h0;
          if (comb_q) begin
            let_d = '{CH_HUM, CH_TEMP, CH_FILT};
            val_d = '{opt_val(th_fitted, hum_code), opt_val(th_fitted, temp_code), co2_filt};
            nf_d = 2'h2;
          end else begin
            let_d[0] = CH_FILT;
            val_d[0] = co2_filt;
            nf_d = 2'h0;
          end
        end
      end
      S_SEP: begin
        bs.data = CH_SP;
        bs.valid = 1'b1;
        if (bs.ready) begin
          st_d = S_LET;
        end
      end
      S_LET: begin
        pi_d = 3'h0;
        dg_d = 4'h0;
        rem_d = val_q[fi_q];
        if (let_q[fi_q] == CH_NONE) begin
          st_d = S_DIG;
        end else begin
          bs.data = let_q[fi_q];
          bs.valid = 1'b1;
          if (bs.ready) begin
            st_d = S_SPC;
          end
        end
      end
      S_SPC: begin
        bs.data = CH_SP;
        bs.valid = 1'b1;
        if (bs.ready) begin
          st_d = S_DIG;
        end
      end
      S_DIG: begin
        // Digit found by repeated subtraction, at most nine steps each
        if (rem_q >= pow10(pi_q)) begin
          rem_d = 16'(rem_q - pow10(pi_q));
          dg_d = 4'(dg_q + 4'h1);
        end else begin
          bs.data = 8'(CH_0 + {4'h0, dg_q});
          bs.valid = 1'b1;
          if (bs.ready) begin
            dg_d = 4'h0;
            pi_d = 3'(pi_q + 3'h1);
            if (pi_q == 3'(DIGITS - 1)) begin
              fi_d = 2'(fi_q + 2'h1);
              st_d = (fi_q == nf_q) ? S_CR : S_SEP;
            end
          end
        end
      end
      S_CR: begin
        bs.data = CH_CR;
        bs.valid = 1'b1;
        if (bs.ready) begin
          st_d = S_LF;
        end
      end
      S_LF: begin
        bs.data = CH_LF;
        bs.valid = 1'b1;
        if (bs.ready) begin
          st_d = S_IDLE;
        end
      end
    endcase
    men_d = (mode_d != MODE_SLEEP);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      mode_q <= MODE_RESET;
      keep_q <= MODE_RESET;
      boot_q <= 1'b1;
      comb_q <= 1'b0;
      men_q <= 1'b0;
      aen_q <= 1'b0;
      spend_q <= 1'b0;
      fs_hi_q <= FS_RESET;
      fs_lo_q <= FS_RESET;
      tick_q <= 26'h0;
      hold_q <= 24'h0;
      let_q <= '{8'h00, 8'h00, 8'h00};
      val_q <= '{16'h0000, 16'h0000, 16'h0000};
      nf_q <= 2'h0;
      fi_q <= 2'h0;
      pi_q <= 3'h0;
      dg_q <= 4'h0;
      rem_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      keep_q <= keep_d;
      boot_q <= 1'b0;
      comb_q <= comb_d;
      men_q <= men_d;
      aen_q <= aen_d;
      spend_q <= spend_d;
      fs_hi_q <= fs_hi_d;
      fs_lo_q <= fs_lo_d;
      tick_q <= tick_d;
      hold_q <= hold_d;
      let_q <= let_d;
      val_q <= val_d;
      nf_q <= nf_d;
      fi_q <= fi_d;
      pi_q <= pi_d;
      dg_q <= dg_d;
      rem_q <= rem_d;
    end
  end

  assign ctrl_mode = mode_q;
  assign keep_mode = keep_q;
  assign meas_enable = men_q;
  assign analog_en = aen_q;
  assign analog_scale = {fs_hi_q, fs_lo_q};

  tx_skid_buf u_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_s(bs.snk),
    .out_data(tx_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_scale_pick: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take && pcmd_q == CH_SCALE && !range_high |=> val_q[0] == 16'h000A)
    else $error("scale reply not 10 for low range");
  a_sleep_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take && sleeping && is_meas |=> st_q == S_IDLE)
    else $error("measurement answered in sleep");
  a_temp_absent: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take && pcmd_q == CH_TEMP && !sleeping && !th_fitted |=> val_q[0] == 16'h0000)
    else $error("temperature not zero without option");
  a_fs_zero_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == S_IDLE && take && pcmd_q == CH_PARAM ##1 analog_scale == 16'h0000 |-> !analog_en)
    else $error("analogue output on with zero scale");
  a_crlf_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == S_CR && bs.ready |=> st_q == S_LF ##[1:300] st_q == S_IDLE)
    else $error("CR not followed by LF");
  a_digit_ascii: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == S_DIG && bs.valid |-> bs.data >= CH_0 && bs.data <= CH_9)
    else $error("non-digit in numeric field");
  a_boot_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boot_q |=> mode_q != MODE_SLEEP && keep_q == mode_q)
    else $error("power-up entered sleep");
  a_hold_bound: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pend_q && st_q == S_IDLE && !sleeping |-> hold_q < 24'(HOLDOFF_CYCLES))
    else $error("command hold-off exceeded");
  a_poll_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_q == MODE_POLL && $past(mode_q) == MODE_POLL && !spend_q |=> !$rose(spend_q))
    else $error("stream output in polling mode");
endmodule

//--- testbench/host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host end of the ASCII command link
// ----------------------------------------
module host_model (
  input wire logic sys_clk,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  byte unsigned got_q[$];

  // Quiet link at time zero
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // One cycle per byte with valid held across the string, CR LF supplied by the caller; idle data is inverted
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge sys_clk);
      rx_byte <= s[i];
      rx_valid <= 1'b1;
    end
    @(posedge sys_clk);
    rx_byte <= ~rx_byte;
    rx_valid <= 1'b0;
  endtask

  // Random stalls so the reply buffer sees back-pressure
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_byte);
    end
    tx_ready <= ($urandom % 4) != 0;
  end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import gas_cmd_pkg::*;
();
  logic sys_clk, sys_rst, rx_valid, tx_valid, tx_ready, th_fitted, range_high, meas_busy;
  logic meas_enable, analog_en;
  logic [7:0] rx_byte, tx_byte;
  logic [15:0] co2_filt, co2_raw, temp_code, hum_code, analog_scale;
  logic [1:0] saved_mode, ctrl_mode, keep_mode;
  int fail_count = 0;
  int total_checks = 0;
  int f, r, t, h, mult, sc;
  bit skip = 0;
  string s;

  // Short stream period and hold-off keep the run brief
  gas_cmd_port #(.STREAM_CYCLES(400), .HOLDOFF_CYCLES(50)) i_gas_cmd_port (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .co2_filt(co2_filt),
    .co2_raw(co2_raw), .temp_code(temp_code), .hum_code(hum_code), .th_fitted(th_fitted),
    .range_high(range_high), .meas_busy(meas_busy), .saved_mode(saved_mode),
    .ctrl_mode(ctrl_mode), .keep_mode(keep_mode), .meas_enable(meas_enable),
    .analog_en(analog_en), .analog_scale(analog_scale));

  host_model i_host_model (.sys_clk(sys_clk), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input string seen, input string exp);
    total_checks++;
    if (seen != exp) begin
      fail_count++;
      $display("ERROR %s expected %s seen %s", what, vis(exp), vis(seen));
    end
  endtask

  function automatic string line(input string l, input int v);
    return $sformatf("%s %05d\r\n", l, v);
  endfunction

  // Combined line: humidity, temperature, filtered reading
  function automatic string all3(input int hv, input int tv, input int fv);
    return $sformatf("H %05d T %05d Z %05d\r\n", hv, tv, fv);
  endfunction

  // Control bytes shown as tildes so an error stays on one line
  function automatic string vis(input string v);
    string o = "";
    for (int i = 0; i < v.len(); i++) begin
      if (v[i] < 8'h20) begin
        o = {o, "~"};
      end else begin
        o = {o, string'(v[i])};
      end
    end
    return o;
  endfunction

  // Bounded wait for one whole reply line
  task automatic get_line(output string o);
    byte unsigned b;
    o = "";
    for (int n = 0; n < 4000; n++) begin
      @(posedge sys_clk);
      while (i_host_model.got_q.size() > 0) begin
        b = i_host_model.got_q.pop_front();
        o = {o, string'(b)};
        if (b == CH_LF) begin
          return;
        end
      end
    end
    fail_count++;
    $display("ERROR reply line expected LF seen timeout");
    end_of_test();
  endtask

  // While streaming, unsolicited reading lines may come before a reply
  task automatic cmd(input string c, input string what, input string exp);
    i_host_model.send({c, "\r\n"});
    for (int k = 0; k < 4; k++) begin
      get_line(s);
      if (!(skip && (s[0] == CH_HUM || s[0] == CH_FILT))) begin
        break;
      end
    end
    check(what, s, exp);
  endtask

  // Reset, then flush the line that may start before the saved mode lands
  task automatic do_reset(input logic [1:0] sm);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    saved_mode <= sm;
    repeat (2) @(posedge sys_clk);
    check("reset state", $sformatf("%b %h %h %b %h", tx_valid, ctrl_mode, keep_mode,
      analog_en, analog_scale), "0 1 1 0 0000");
    sys_rst <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("boot mode", $sformatf("%h %h %b", ctrl_mode, keep_mode, meas_enable),
      $sformatf("%0d %0d 1", (sm == 2'h2) ? 2 : 1, (sm == 2'h2) ? 2 : 1));
    repeat (300) @(posedge sys_clk);
    i_host_model.got_q.delete();
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h7783));
    sys_rst = 1'b1;
    {co2_filt, co2_raw, temp_code, hum_code} = '0;
    {th_fitted, range_high, meas_busy} = 3'b000;
    saved_mode = 2'h0;
    do_reset(MODE_POLL);
    $display("test boot done");
    // Readouts, first fitted and low range, then unfitted, high range, busy
    for (int rep = 0; rep < 2; rep++) begin
      f = $urandom % 65536;
      r = $urandom % 65536;
      t = 1000 + $urandom % 600;
      h = $urandom % 1001;
      @(posedge sys_clk);
      co2_filt <= 16'(f);
      co2_raw <= 16'(r);
      temp_code <= 16'(t);
      hum_code <= 16'(h);
      th_fitted <= (rep == 0);
      range_high <= (rep == 1);
      meas_busy <= (rep == 1);
      mult = (rep == 1) ? 100 : 10;
      t = (rep == 1) ? 0 : t;
      h = (rep == 1) ? 0 : h;
      cmd("z", "raw reply", line("z", r));
      cmd("Z", "filtered reply", line("Z", f));
      cmd(".", "scale reply", line(".", mult));
      cmd("T", "temperature reply", line("T", t));
      cmd("H", "humidity reply", line("H", h));
      cmd("Q", "combined reply", all3(h, t, f));
    end
    meas_busy <= 1'b0;
    $display("test readouts done");
    // Broken commands act on nothing; only the last whole one answers
    i_host_model.send("Z");
    i_host_model.send("Z\n");
    cmd("H", "partial commands", line("H", 0));
    repeat (200) @(posedge sys_clk);
    check("extra bytes", $sformatf("%0d", i_host_model.got_q.size()), "0");
    // Full scale of 60000 ppm sent in scaled units, high byte first
    sc = 60000 / mult;
    cmd($sformatf("P 0 %0d", sc / 256), "scale high",
      $sformatf("P 00000 %05d\r\n", sc / 256));
    cmd($sformatf("P 1 %0d", sc % 256), "scale low",
      $sformatf("P 00001 %05d\r\n", sc % 256));
    check("analog on", $sformatf("%b %h", analog_en, analog_scale),
      $sformatf("1 %h", 16'(sc)));
    cmd("P 0 0", "zero high", "P 00000 00000\r\n");
    cmd("P 1 0", "zero low", "P 00001 00000\r\n");
    check("analog off", $sformatf("%b %h", analog_en, analog_scale), "0 0000");
    $display("test full scale done");
    // Polling sends nothing unasked; streaming follows the output mask
    check("poll quiet", $sformatf("%0d", i_host_model.got_q.size()), "0");
    cmd("M 4164", "mask echo", line("M", 4164));
    skip = 1;
    cmd("K 1", "stream echo", line("K", 1));
    get_line(s);
    check("combined stream", s, all3(h, t, f));
    cmd("M 0", "mask echo", line("M", 0));
    get_line(s);
    get_line(s);
    check("filtered stream", s, line("Z", f));
    $display("test streaming done");
    // Sleep refuses readings, still answers others, and is not kept
    cmd("K 0", "sleep echo", line("K", 0));
    check("sleep state",
      $sformatf("%h %h %b", ctrl_mode, keep_mode, meas_enable), "0 1 0");
    i_host_model.send("z\r\n");
    repeat (300) @(posedge sys_clk);
    check("sleep refusal", $sformatf("%0d", i_host_model.got_q.size()), "0");
    cmd(".", "sleep scale", line(".", mult));
    do_reset(keep_mode);
    $display("test sleep done");
    end_of_test();
  end
endmodule
